// ### ssu_shift_unit.sv
// shift and scale unit: counted shifts and normalise-and-count
`timescale 1ns/1ns
module ssu_shift_unit
(
    clk,
    rst,
    start,
    instr,
    shiftCount,
    regA,
    regA1,
    opWord,
    opWord1,
    busy,
    done,
    reject,
    regSel,
    writeA,
    writeA1,
    writeA2,
    dataA,
    dataA1,
    dataA2
);
    import ssu_pkg::*;

    input wire logic clk;
    input wire logic rst;
    input wire logic start;
    input wire logic [ssu_pkg::WORD_W-1:0] instr;
    input wire logic [ssu_pkg::CNT_IN_W-1:0] shiftCount;
    input wire logic [ssu_pkg::WORD_W-1:0] regA;
    input wire logic [ssu_pkg::WORD_W-1:0] regA1;
    input wire logic [ssu_pkg::WORD_W-1:0] opWord;
    input wire logic [ssu_pkg::WORD_W-1:0] opWord1;
    output logic busy;
    output logic done;
    output logic reject;
    output logic [ssu_pkg::REG_W-1:0] regSel;
    output logic writeA;
    output logic writeA1;
    output logic writeA2;
    output logic [ssu_pkg::WORD_W-1:0] dataA;
    output logic [ssu_pkg::WORD_W-1:0] dataA1;
    output logic [ssu_pkg::WORD_W-1:0] dataA2;

    ssu_state_t state_reg;
    ssu_state_t state_next;
    ssu_minor_t minor;
    ssu_minor_t minor_reg;
    logic majorHit;
    logic known;
    logic isNorm;
    logic accept;
    logic [CLIP_W-1:0] clipCount;
    logic [WORD_W-1:0] shiftA;
    logic [WORD_W-1:0] shiftA1;
    logic shiftPair;
    logic [3*WORD_W-1:0] tripleWord;
    logic [2*PAIR_W-1:0] doublePair;
    logic [PAIR_W-1:0] pairIn;
    logic snLoad;
    logic snBusy;
    logic snDone;
    logic [WORD_W-1:0] snResult;
    logic [CLIP_W-1:0] snPlaces;
    logic pnLoad;
    logic pnBusy;
    logic pnDone;
    logic [PAIR_W-1:0] pnResult;
    logic [CLIP_W-1:0] pnPlaces;

    // instruction decode
    assign majorHit = instr[OP_MSB:OP_LSB] == MAJOR_SHIFT; // RULE_01
    assign minor = ssu_minor_t'(instr[MINOR_MSB:MINOR_LSB]); // RULE_01
    assign known = instr[MINOR_MSB:MINOR_LSB] <= MN_PAIR_ROTATE_LEFT; // RULE_16
    assign isNorm = (minor == MN_LOAD_NORMALISE_COUNT)
        || (minor == MN_PAIR_LOAD_NORMALISE);
    assign accept = start && (state_reg == ST_IDLE) && majorHit && known;
    assign snLoad = accept && (minor == MN_LOAD_NORMALISE_COUNT);
    assign pnLoad = accept && (minor == MN_PAIR_LOAD_NORMALISE);

    // count clipped to the pair width; larger counts are undefined anyway
    always_comb
    begin
        if (shiftCount > CNT_IN_W'(COUNT_LIMIT)) // RULE_20
            clipCount = COUNT_LIMIT;
        else
            clipCount = shiftCount[CLIP_W-1:0]; // RULE_19
    end

    // repeated copies make every rotate a plain shift of a wider word
    assign pairIn = {regA, regA1};
    assign tripleWord = {regA, regA, regA};
    assign doublePair = {pairIn, pairIn};

    // counted shift barrel; a zero count passes the operand straight through
    always_comb
    begin
        shiftA = regA; // RULE_21
        shiftA1 = regA1;
        shiftPair = 1'b0;
        case (minor)
            MN_SINGLE_ROTATE_RIGHT:
            begin
                shiftA = WORD_W'(tripleWord >> clipCount); // RULE_18
            end
            MN_PAIR_ROTATE_RIGHT:
            begin
                {shiftA, shiftA1} = // RULE_02
                    PAIR_W'(doublePair >> clipCount);
                shiftPair = 1'b1;
            end
            MN_SINGLE_LOGICAL_RIGHT:
            begin
                shiftA = regA >> clipCount; // RULE_03
            end
            MN_PAIR_LOGICAL_RIGHT:
            begin
                {shiftA, shiftA1} = pairIn >> clipCount; // RULE_04
                shiftPair = 1'b1;
            end
            MN_SINGLE_ARITH_RIGHT:
            begin
                shiftA = WORD_W'($signed(regA) >>> clipCount); // RULE_05
            end
            MN_PAIR_ARITH_RIGHT:
            begin
                {shiftA, shiftA1} = // RULE_06
                    PAIR_W'($signed(pairIn) >>> clipCount);
                shiftPair = 1'b1;
            end
            MN_SINGLE_ROTATE_LEFT:
            begin
                shiftA = tripleWord[3*WORD_W-1-:WORD_W] == WORD_ZERO // RULE_15
                    ? WORD_ZERO
                    : WORD_W'((tripleWord << clipCount) >> (2 * WORD_W));
            end
            MN_PAIR_ROTATE_LEFT:
            begin
                {shiftA, shiftA1} = // RULE_16 RULE_17
                    PAIR_W'((doublePair << clipCount) >> PAIR_W);
                shiftPair = 1'b1;
            end
            default:
            begin
                shiftA = regA;
                shiftA1 = regA1;
                shiftPair = 1'b0;
            end
        endcase
    end

    // single-word normaliser
    ssu_normaliser #(.W(WORD_W), .CW(CLIP_W)) singleNorm
    (
        .clk(clk),
        .rst(rst),
        .load(snLoad),
        .value(opWord), // RULE_07
        .busy(snBusy),
        .done(snDone),
        .result(snResult),
        .places(snPlaces)
    );

    // pair normaliser, first word forms the high half
    ssu_normaliser #(.W(PAIR_W), .CW(CLIP_W)) pairNorm
    (
        .clk(clk),
        .rst(rst),
        .load(pnLoad),
        .value({opWord, opWord1}), // RULE_11
        .busy(pnBusy),
        .done(pnDone),
        .result(pnResult),
        .places(pnPlaces)
    );

    // sequencing: counted shifts take one cycle, normalising waits
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (accept && isNorm)
                    state_next = ST_NORM;
            end
            ST_NORM:
            begin
                if (snDone || pnDone)
                    state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // operation and register designator held for the whole instruction
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            minor_reg <= MN_SINGLE_ROTATE_RIGHT;
            regSel <= {REG_W{1'b0}};
        end
        else if (accept)
        begin
            minor_reg <= minor;
            regSel <= instr[REG_MSB:REG_LSB];
        end
    end

    // busy, done and reject flags
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            reject <= 1'b0;
        end
        else
        begin
            busy <= (state_next == ST_NORM);
            done <= (accept && !isNorm) || (state_reg == ST_NORM
                && (snDone || pnDone));
            reject <= start && (state_reg == ST_IDLE) && !(majorHit && known);
        end
    end

    // result writes to A, A+1 and A+2
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            writeA <= 1'b0;
            writeA1 <= 1'b0;
            writeA2 <= 1'b0;
            dataA <= WORD_ZERO;
            dataA1 <= WORD_ZERO;
            dataA2 <= WORD_ZERO;
        end
        else if (accept && !isNorm)
        begin
            writeA <= 1'b1;
            writeA1 <= shiftPair;
            writeA2 <= 1'b0;
            dataA <= shiftA;
            dataA1 <= shiftA1;
            dataA2 <= WORD_ZERO;
        end
        else if (state_reg == ST_NORM && snDone)
        begin
            writeA <= 1'b1; // RULE_08
            writeA1 <= 1'b1; // RULE_09
            writeA2 <= 1'b0;
            dataA <= snResult;
            dataA1 <= WORD_W'(snPlaces); // RULE_09 RULE_22
            dataA2 <= WORD_ZERO;
        end
        else if (state_reg == ST_NORM && pnDone)
        begin
            writeA <= 1'b1; // RULE_12
            writeA1 <= 1'b1;
            writeA2 <= 1'b1; // RULE_13
            dataA <= pnResult[PAIR_W-1:WORD_W];
            dataA1 <= pnResult[WORD_W-1:0];
            dataA2 <= WORD_W'(pnPlaces); // RULE_13 RULE_22
        end
        else
        begin
            writeA <= 1'b0;
            writeA1 <= 1'b0;
            writeA2 <= 1'b0;
        end
    end

    // checks on the shift unit behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic [WORD_W-1:0] regACopy;
    assign regACopy = regA;

    counted_done_a: assert property (accept && !isNorm // RULE_01
        |=> done && writeA)
        else $error("counted shift did not complete next cycle");
    logical_right_a: assert property (accept // RULE_03
        && minor == MN_SINGLE_LOGICAL_RIGHT
        |=> dataA == ($past(regACopy) >> $past(clipCount)))
        else $error("single logical right result wrong");
    arith_sign_a: assert property (accept // RULE_05
        && minor == MN_SINGLE_ARITH_RIGHT && regA[WORD_W-1]
        |=> dataA[WORD_W-1])
        else $error("arithmetic right lost the sign");
    zero_count_a: assert property (accept && !isNorm // RULE_21
        && shiftCount == CNT_IN_W'(COUNT_ZERO)
        |=> dataA == $past(regA) && (!writeA1 || dataA1 == $past(regA1)))
        else $error("zero count changed the operand");
    rotate_ones_a: assert property (accept // RULE_17
        && (minor == MN_PAIR_ROTATE_LEFT || minor == MN_PAIR_ROTATE_RIGHT)
        |=> $countones({dataA, dataA1}) == $countones($past(pairIn)))
        else $error("pair rotate lost bits");
    single_norm_a: assert property (writeA1 && !writeA2 && done // RULE_08
        && minor_reg == MN_LOAD_NORMALISE_COUNT
        |-> dataA[WORD_W-1] != dataA[WORD_W-2] || dataA1 == SINGLE_FULL)
        else $error("single normalise result not scaled");
    single_count_a: assert property (writeA1 && done // RULE_22
        && minor_reg == MN_LOAD_NORMALISE_COUNT |-> dataA1 <= SINGLE_FULL)
        else $error("single normalise count out of range");
    pair_count_a: assert property (writeA2 |-> dataA2 <= PAIR_FULL // RULE_13
        && (dataA[WORD_W-1] != dataA[WORD_W-2] || dataA2 == PAIR_FULL))
        else $error("pair normalise count or result wrong");
    degenerate_a: assert property (snLoad && opWord == WORD_ZERO // RULE_10
        |-> ##2 done && dataA1 == SINGLE_FULL)
        else $error("all-zero operand did not give full count");
    norm_latency_a: assert property (pnLoad |-> ##[2:74] done) // RULE_12
        else $error("pair normalise did not finish");
    norm_busy_a: assert property (snBusy || pnBusy // RULE_08
        |-> state_reg == ST_NORM && busy)
        else $error("normaliser running outside the wait state");
    done_idle_a: assert property (done |-> !busy && !reject) // RULE_08
        else $error("completion while still busy");

    counted_c: cover property (accept && minor == MN_PAIR_ROTATE_RIGHT);
    single_norm_c: cover property (snLoad ##[2:40] done);
    pair_norm_c: cover property (pnLoad ##[2:74] writeA2);
    reject_c: cover property (reject);
endmodule

// ### ssu_pkg.sv
// shift unit constants, minor code enumeration and the normalising rotator
// How it works
// (RULE_01) major code 73 octal in bits 35..30, minor code 29..26 picks op
// (RULE_02) pair rotate right: A and A+1 form 72 bits, A+1 low re-enters A top
// (RULE_03) single logical right: A shifted right, zeros fill the top
// (RULE_04) pair logical right: 72-bit pair shifted right, zeros fill top of A
// (RULE_05) single arithmetic right: A shifted right, sign copies fill the top
// (RULE_06) pair arithmetic right: pair shifted right, sign fills top of A
// (RULE_07) single normalise: fetched operand word is loaded into the rotator
// (RULE_08) single normalise: rotate left until bit 35 differs, then write A
// (RULE_09) single normalise: number of places shifted goes to A+1
// (RULE_10) single normalise: operand all zeros or all ones gives count 35
// (RULE_11) pair normalise: two operand words load A and A+1 as 72 bits
// (RULE_12) pair normalise: rotate left until bit 71 differs, write A and A+1
// (RULE_13) pair normalise: number of places shifted goes to A+2
// (RULE_14) pair normalise: operand all zeros or all ones gives count 71
// (RULE_15) single rotate left: bits leaving the top re-enter at the bottom
// (RULE_16) minor code 11 octal decodes as pair rotate left
// (RULE_17) pair rotate left: top of A re-enters the low end of A+1
// (RULE_18) minor code 00 is single rotate right, low bits re-enter the top
// (RULE_19) count is the index-modified address or the indirect operand
// (RULE_20) software keeps counts at or below 72; larger are undefined
// (RULE_21) a zero count leaves the register or pair unchanged
// (RULE_22) normalise count is unsigned, right-justified, upper bits cleared
`timescale 1ns/1ns
package ssu_pkg;
    localparam int WORD_W = 36;
    localparam int PAIR_W = 72;
    localparam int CNT_IN_W = 18;
    localparam int CLIP_W = 7;
    localparam int REG_W = 4;
    localparam int OP_MSB = 35;
    localparam int OP_LSB = 30;
    localparam int MINOR_MSB = 29;
    localparam int MINOR_LSB = 26;
    localparam int REG_MSB = 25;
    localparam int REG_LSB = 22;
    localparam logic [5:0] MAJOR_SHIFT = 6'h3B;
    localparam logic [CLIP_W-1:0] COUNT_LIMIT = 7'h48;
    localparam logic [CLIP_W-1:0] COUNT_ZERO = 7'h00;
    localparam logic [WORD_W-1:0] WORD_ZERO = 36'h0_0000_0000;
    localparam logic [WORD_W-1:0] SINGLE_FULL = 36'h0_0000_0023;
    localparam logic [WORD_W-1:0] PAIR_FULL = 36'h0_0000_0047;

    typedef enum logic [3:0] {
        MN_SINGLE_ROTATE_RIGHT = 4'h0,
        MN_PAIR_ROTATE_RIGHT = 4'h1,
        MN_SINGLE_LOGICAL_RIGHT = 4'h2,
        MN_PAIR_LOGICAL_RIGHT = 4'h3,
        MN_SINGLE_ARITH_RIGHT = 4'h4,
        MN_PAIR_ARITH_RIGHT = 4'h5,
        MN_LOAD_NORMALISE_COUNT = 4'h6,
        MN_PAIR_LOAD_NORMALISE = 4'h7,
        MN_SINGLE_ROTATE_LEFT = 4'h8,
        MN_PAIR_ROTATE_LEFT = 4'h9
    } ssu_minor_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_NORM = 2'b01
    } ssu_state_t;
endpackage

// rotates left one place per clock until the two top bits differ
module ssu_normaliser
#(
    parameter int W = 36,
    parameter int CW = 7
)
(
    clk,
    rst,
    load,
    value,
    busy,
    done,
    result,
    places
);
    input wire logic clk;
    input wire logic rst;
    input wire logic load;
    input wire logic [W-1:0] value;
    output logic busy;
    output logic done;
    output logic [W-1:0] result;
    output logic [CW-1:0] places;

    localparam logic [CW-1:0] FULL = CW'(W - 1);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic degenerate;
    assign degenerate = (value == {W{1'b0}}) || (value == {W{1'b1}});

    // busy and completion pulse
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (load)
        begin
            busy <= !degenerate;
            done <= degenerate; // RULE_10 RULE_14
        end
        else if (busy && (result[W-1] != result[W-2]))
        begin
            busy <= 1'b0;
            done <= 1'b1; // RULE_08 RULE_12
        end
        else
        begin
            done <= 1'b0;
        end
    end

    // shift path and count of places moved
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            result <= {W{1'b0}};
            places <= {CW{1'b0}};
        end
        else if (load)
        begin
            result <= value; // RULE_07 RULE_11
            places <= degenerate ? FULL : {CW{1'b0}}; // RULE_10 RULE_14
        end
        else if (busy && (result[W-1] == result[W-2]))
        begin
            result <= {result[W-2:0], result[W-1]}; // RULE_08 RULE_12
            places <= places + ONE;
        end
    end
endmodule

// ### ssu_decoder_model.sv
// decoder and operand fetch model that presents shift requests
`timescale 1ns/1ns
module ssu_decoder_model
(
    input wire logic clk,
    input wire logic done,
    input wire logic reject,
    output logic start,
    output logic [ssu_pkg::WORD_W-1:0] instr,
    output logic [ssu_pkg::CNT_IN_W-1:0] shiftCount,
    output logic [ssu_pkg::WORD_W-1:0] regA,
    output logic [ssu_pkg::WORD_W-1:0] regA1,
    output logic [ssu_pkg::WORD_W-1:0] opWord,
    output logic [ssu_pkg::WORD_W-1:0] opWord1
);
    import ssu_pkg::*;
    // quiet request lines from time zero
    initial
    begin
        start = 1'b0;
        {instr, shiftCount, regA, regA1, opWord, opWord1} = '0;
    end
    // one request per edge; a following call keeps start high
    task automatic issue(input logic [WORD_W-1:0] ins, a, a1, u, u1,
        input logic [6:0] n);
        @(negedge clk);
        start = 1'b1;
        instr = ins;
        shiftCount = {11'h000, (n > 7'h48) ? 7'h48 : n};
        regA = a;
        regA1 = a1;
        opWord = u;
        opWord1 = u1;
    endtask
    // released lines stop showing the last request
    task automatic drop();
        @(negedge clk);
        start = 1'b0;
        {instr, regA, regA1, opWord, opWord1} =
            ~{instr, regA, regA1, opWord, opWord1};
    endtask
    // bounded wait for the end of a normalise
    task automatic wait_done(output bit seen);
        int i;
        seen = 1'b0;
        for (i = 0; i < 200 && !seen; i++)
        begin
            @(negedge clk);
            seen = done || reject;
        end
    endtask
endmodule

// ### ssu_shift_unit_tb_top.sv
// self-checking bench for the shift and scale unit
`timescale 1ns/1ns
module ssu_shift_unit_tb_top;
    import ssu_pkg::*;
    typedef struct packed {
        logic [4:0] flg;
        logic [REG_W-1:0] sel;
        logic [WORD_W-1:0] d0;
        logic [WORD_W-1:0] d1;
        logic [WORD_W-1:0] d2;
    } ssu_exp_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start, busy, done, reject, writeA, writeA1, writeA2;
    logic [WORD_W-1:0] instr, regA, regA1, opWord, opWord1;
    logic [WORD_W-1:0] dataA, dataA1, dataA2;
    logic [CNT_IN_W-1:0] shiftCount;
    logic [REG_W-1:0] regSel;
    ssu_exp_t expQ[$];
    ssu_exp_t e;
    int miscompares = 0;
    int numChecks = 0;

    ssu_shift_unit u_ssu_shift_unit (.clk, .rst, .start, .instr, .shiftCount,
        .regA, .regA1, .opWord, .opWord1, .busy, .done, .reject, .regSel,
        .writeA, .writeA1, .writeA2, .dataA, .dataA1, .dataA2);
    ssu_decoder_model u_ssu_decoder_model (.clk, .done, .reject, .start,
        .instr, .shiftCount, .regA, .regA1, .opWord, .opWord1);

    // 250 MHz clock
    always #2 clk = ~clk;

    // comparison helpers
    task automatic cmp_word(input logic [WORD_W-1:0] got, exp);
        numChecks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t word %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flags(input logic [4:0] got, exp);
        numChecks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t flags %b exp %b", $time, got, exp);
        end
    endtask

    // rotate helpers for the expectations
    function automatic logic [35:0] rr36(input logic [35:0] x, input int k);
        logic [71:0] t;
        t = {x, x} >> (k % 36);
        return t[35:0];
    endfunction
    function automatic logic [71:0] rr72(input logic [71:0] x, input int k);
        logic [143:0] t;
        t = {x, x} >> (k % 72);
        return t[71:0];
    endfunction
    // left rotate until the top bits differ; 7F marks a uniform word
    function automatic logic [78:0] norm(input logic [71:0] x);
        logic [6:0] k;
        k = 7'h00;
        if (x == '0 || x == '1)
            return {7'h7F, x};
        while (x[71] == x[70])
        begin
            x = {x[70:0], x[71]};
            k++;
        end
        return {k, x};
    endfunction

    // expected writes for one instruction
    function automatic ssu_exp_t model(input logic [WORD_W-1:0] ins, a, a1,
        u, u1, input int n);
        ssu_exp_t r;
        logic [3:0] mn;
        logic [71:0] p, v;
        logic [6:0] k;
        r = '0;
        mn = ins[MINOR_MSB:MINOR_LSB];
        r.sel = ins[REG_MSB:REG_LSB];
        r.flg = (mn inside {4'h1, 4'h3, 4'h5, 4'h9}) ? 5'h16 : 5'h14;
        p = {a, a1};
        {k, v} = norm(mn == 4'h7 ? {u, u1} : {u, u});
        case (mn)
            4'h0: r.d0 = rr36(a, n);
            4'h1: {r.d0, r.d1} = rr72(p, n);
            4'h2: r.d0 = a >> n;
            4'h3: {r.d0, r.d1} = p >> n;
            4'h4: r.d0 = $signed(a) >>> n;
            4'h5: {r.d0, r.d1} = $signed(p) >>> n;
            4'h6: {r.flg, r.d0, r.d1} = {5'h16, v[71:36], 29'h0,
                k == 7'h7F ? 7'h23 : k};
            4'h7: {r.flg, r.d0, r.d1, r.d2} = {5'h17, v, 29'h0,
                k == 7'h7F ? 7'h47 : k};
            4'h8: r.d0 = rr36(a, 36 - n % 36);
            4'h9: {r.d0, r.d1} = rr72(p, 72 - n % 72);
            default: r.flg = 5'h08;
        endcase
        if (ins[OP_MSB:OP_LSB] !== MAJOR_SHIFT)
            r.flg = 5'h08;
        return r;
    endfunction

    function automatic logic [WORD_W-1:0] rnd();
        return 36'({$urandom(), $urandom()});
    endfunction

    // note the expectation, then hand the request to the model
    task automatic send(input logic [5:0] maj, input logic [3:0] mn,
        input logic [6:0] n, input logic [WORD_W-1:0] a, a1, u, u1);
        logic [WORD_W-1:0] ins;
        ins = {maj, mn, 4'($urandom()), 22'($urandom())};
        expQ.push_back(model(ins, a, a1, u, u1, n));
        u_ssu_decoder_model.issue(ins, a, a1, u, u1, n);
    endtask

    // pair each completion with the oldest expectation
    always @(negedge clk)
    begin
        if (!rst && (done === 1'b1 || reject === 1'b1))
        begin
            e = '0;
            if (expQ.size() > 0)
                e = expQ.pop_front();
            cmp_flags({done, reject, writeA, writeA1, writeA2},
                e.flg);
            cmp_flags({4'h0, busy}, 5'h00);
            if (e.flg[2])
                cmp_word(dataA, e.d0);
            if (e.flg[1])
                cmp_word(dataA1, e.d1);
            if (e.flg[0])
                cmp_word(dataA2, e.d2);
            if (e.flg[4])
                cmp_word({32'h0, regSel}, {32'h0, e.sel});
        end
    end

    task automatic end_test(input string name);
        repeat (4) @(negedge clk);
        $display("test %s done at %0t", name, $time);
    endtask

    task automatic conclude();
        cmp_word(36'(expQ.size()), 36'h0);
        $display("checks %0d miscompares %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // cut a hang short after 20000 cycles
    initial
    begin
        #80000;
        miscompares++;
        conclude();
    end

    // main sequence
    initial
    begin
        int i, j;
        bit seen;
        logic [WORD_W-1:0] a;
        logic [3:0] codes [8];
        logic [WORD_W-1:0] tbl [4];
        codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9};
        tbl = '{36'h0, 36'hF_FFFF_FFFF, 36'h0_0000_0001, 36'h0_00CB_B151};
        void'($urandom(32'hE991));
        repeat (20) @(negedge clk);
        rst = 1'b0;
        // counted shifts back to back: counts 0, 72 and random
        foreach (codes[i])
            for (j = 0; j < 12; j++)
                send(6'h3B, codes[i], j == 0 ? 7'h00 :
                    j == 1 ? 7'h48 : 7'($urandom_range(72)),
                    rnd(), rnd(), rnd(), rnd());
        u_ssu_decoder_model.drop();
        end_test("counted");
        // single and pair normalise: uniform, short and random operands
        for (i = 0; i < 16; i++)
        begin
            a = i < 8 ? tbl[i / 2] : rnd() >> $urandom_range(35);
            send(6'h3B, i[0] ? 4'h7 : 4'h6, 7'h00, rnd(), rnd(), a,
                i < 8 ? tbl[i / 2] : rnd());
            u_ssu_decoder_model.drop();
            cmp_flags({4'h0, busy}, 5'h01);
            u_ssu_decoder_model.wait_done(seen);
            cmp_flags({3'h0, busy, seen}, 5'h01);
        end
        end_test("normalise");
        // a request while normalising is dropped silently
        send(6'h3B, 4'h6, 7'h00, rnd(), rnd(), 36'h0_0000_0001,
            rnd());
        u_ssu_decoder_model.drop();
        repeat (3) @(negedge clk);
        u_ssu_decoder_model.issue(rnd(), rnd(), rnd(), rnd(), rnd(), 7'h05);
        u_ssu_decoder_model.drop();
        u_ssu_decoder_model.wait_done(seen);
        cmp_flags({3'h0, busy, seen}, 5'h01);
        end_test("busy");
        // undefined minor codes and a foreign major code are refused
        for (i = 10; i < 17; i++)
        begin
            send(i < 16 ? 6'h3B : 6'h3A, 4'(i), 7'h03, rnd(), rnd(), rnd(),
                rnd());
            u_ssu_decoder_model.drop();
            repeat (2) @(negedge clk);
        end
        end_test("refused");
        conclude();
    end
endmodule
